// file: inc/ira_link_if.sv
`timescale 1ns/1ps
interface ira_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Pull-ups: a line is low only while someone drives a low on it
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input scl,
    input sda
  );

  modport device (
    output s_sda_o,
    output s_sda_oe,
    input scl,
    input sda
  );
endinterface : ira_link_if

// file: inc/ira_pkg.sv
package ira_pkg;
  // Timing of the serial clock made by the master end
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 160;
  localparam int QUARTERS_PER_BIT = 4;
  localparam int QUARTER_CYC_RAW =
    LINK_PERIOD_NS / (CLK_PERIOD_NS * QUARTERS_PER_BIT);
  localparam int QUARTER_CYC = (QUARTER_CYC_RAW < 1) ? 1 : QUARTER_CYC_RAW;
  localparam logic [3:0] QUARTER_LAST = 4'(QUARTER_CYC - 1);

  // Quarters of one bit cell on the master side
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HOLD = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  // Framing
  localparam logic [6:0] SLAVE_ADDR = 7'h35;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_STEP = 4'h1;

  // Register bank
  localparam int REG_COUNT = 256;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [7:0] LEN_TWO = 8'h02;
  localparam logic [7:0] LEN_ZERO = 8'h00;

  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_RECOVER} ira_op_type;

  // Open-drain enable for a data bit: pull low for a zero
  function automatic logic ira_od_oe(input logic bit_val);
    return !bit_val;
  endfunction : ira_od_oe
endpackage : ira_pkg

// file: logic/ira_device.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Write address with R/W low starts write
// R2 - First byte after write address loads pointer
// R3 - STOP after pointer keeps pointer, no writes
// R4 - Data bytes stored at pointer, pointer increments
// R5 - Reads send register at pointer, then increment
// R6 - First read byte uses last written pointer
// R7 - Master sets pointer, repeated START, then reads
// R8 - Master NACK ends read; device releases data
// R9 - Master sends STOP after bus suspend
// R10 - Reset holds logic in known default state
// R11 - Answer only the own seven-bit address
// R12 - Ninth clock carries receiver acknowledge low
// R13 - Pointer clears to zero at reset
module ira_device
  import ira_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  ira_link_if.device link,
  input wire logic [7:0] usr_addr,
  output logic [7:0] usr_rd_data_q,
  output logic wr_stb_q,
  output logic [7:0] wr_addr_q,
  output logic [7:0] wr_data_q,
  output logic [7:0] ptr_q,
  output logic busy_q
);
  import ira_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_AACK, D_RX, D_WACK, D_TX, D_MACK
  } ira_dev_state_type;

  ira_dev_state_type st_q;
  logic [7:0] regs_q [REG_COUNT];
  logic [3:0] cnt_q;
  logic [7:0] shreg_q;
  logic [7:0] txsh_q;
  logic rw_q;
  logic first_q;
  logic mnack_q;
  logic sda_oe_q;
  logic scl_s1_q;
  logic scl_s2_q;
  logic scl_p_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_end;
  logic ev_ptr;
  logic ev_wr;
  logic ev_tx_done;

  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe = sda_oe_q;

  // Both pins pass two flip-flops before any edge logic sees them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_s1_q <= link.scl;
      scl_s2_q <= scl_s1_q;
      scl_p_q <= scl_s2_q;
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
      sda_p_q <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q && !scl_p_q;
  assign scl_fall = !scl_s2_q && scl_p_q;
  assign bus_start = scl_s2_q && scl_p_q && sda_p_q && !sda_s2_q;
  assign bus_stop = scl_s2_q && scl_p_q && !sda_p_q && sda_s2_q;
  assign byte_end = scl_fall && (cnt_q == BIT_ACK);

  // Byte-level events that move the pointer and the bank
  assign ev_ptr = !bus_start && !bus_stop && byte_end &&
    (st_q == D_RX) && first_q;
  assign ev_wr = !bus_start && !bus_stop && byte_end &&
    (st_q == D_RX) && !first_q;
  assign ev_tx_done = !bus_start && !bus_stop && byte_end &&
    (st_q == D_TX);

  // Bit and byte sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= D_IDLE; // see R10
      cnt_q <= BIT_FIRST;
      shreg_q <= 8'h00;
      txsh_q <= 8'h00;
      rw_q <= RW_WRITE;
      first_q <= 1'b0;
      mnack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (ce) begin
      if (bus_start) begin
        // START or repeated START always restarts address capture
        st_q <= D_ADDR;
        cnt_q <= BIT_FIRST;
        sda_oe_q <= 1'b0;
      end else if (bus_stop) begin
        // Bus returns idle; a pointer just loaded stays (see R3)
        st_q <= D_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (st_q)
          D_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          D_ADDR: begin
            if (scl_rise) begin
              shreg_q <= {shreg_q[6:0], sda_s2_q};
              cnt_q <= cnt_q + BIT_STEP;
            end else if (byte_end) begin
              if (shreg_q[7:1] == SLAVE_ADDR) begin // see R11
                rw_q <= shreg_q[0];
                sda_oe_q <= 1'b1; // see R12
                st_q <= D_AACK;
              end else begin
                st_q <= D_IDLE;
              end
            end
          end
          D_AACK: begin
            if (scl_fall) begin
              cnt_q <= BIT_FIRST;
              if (rw_q == RW_READ) begin
                // Read begins at the stored pointer (see R5) (see R6)
                txsh_q <= regs_q[ptr_q];
                sda_oe_q <= ira_od_oe(regs_q[ptr_q][7]);
                st_q <= D_TX;
              end else begin
                // Write access: next byte is the pointer (see R1)
                first_q <= 1'b1;
                sda_oe_q <= 1'b0;
                st_q <= D_RX;
              end
            end
          end
          D_RX: begin
            if (scl_rise) begin
              shreg_q <= {shreg_q[6:0], sda_s2_q};
              cnt_q <= cnt_q + BIT_STEP;
            end else if (byte_end) begin
              first_q <= 1'b0;
              sda_oe_q <= 1'b1; // see R12
              st_q <= D_WACK;
            end
          end
          D_WACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              cnt_q <= BIT_FIRST;
              st_q <= D_RX;
            end
          end
          D_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + BIT_STEP;
            end else if (byte_end) begin
              sda_oe_q <= 1'b0;
              st_q <= D_MACK;
            end else if (scl_fall) begin
              txsh_q <= {txsh_q[6:0], 1'b0};
              sda_oe_q <= ira_od_oe(txsh_q[6]);
            end
          end
          D_MACK: begin
            if (scl_rise) begin
              mnack_q <= sda_s2_q;
            end else if (scl_fall) begin
              cnt_q <= BIT_FIRST;
              if (mnack_q) begin
                // Master NACK: line stays released (see R8)
                sda_oe_q <= 1'b0;
                st_q <= D_IDLE;
              end else begin
                txsh_q <= regs_q[ptr_q];
                sda_oe_q <= ira_od_oe(regs_q[ptr_q][7]);
                st_q <= D_TX;
              end
            end
          end
          default: begin
            sda_oe_q <= 1'b0;
            st_q <= D_IDLE;
          end
        endcase
      end
    end
  end

  // Register pointer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= PTR_RESET; // see R13
    end else if (ce) begin
      if (ev_ptr) begin
        ptr_q <= shreg_q; // see R2
      end else if (ev_wr || ev_tx_done) begin
        ptr_q <= ptr_q + PTR_STEP; // see R4 see R5
      end
    end
  end

  // Register bank
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_RESET; // see R10
      end
    end else if (ce) begin
      if (ev_wr) begin
        regs_q[ptr_q] <= shreg_q; // see R4
      end
    end
  end

  // User-side view of the bank and of serial writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      usr_rd_data_q <= REG_RESET;
      wr_stb_q <= 1'b0;
      wr_addr_q <= PTR_RESET;
      wr_data_q <= REG_RESET;
      busy_q <= 1'b0;
    end else if (ce) begin
      usr_rd_data_q <= regs_q[usr_addr];
      wr_stb_q <= ev_wr;
      if (ev_wr) begin
        wr_addr_q <= ptr_q;
        wr_data_q <= shreg_q;
      end
      busy_q <= (st_q != D_IDLE);
    end
  end
endmodule : ira_device

// file: logic/ira_master.sv
`timescale 1ns/1ps
module ira_master
  import ira_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  ira_link_if.master link,
  input wire logic cmd_valid,
  input wire ira_pkg::ira_op_type cmd_op,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] wr_data,
  output logic busy_q,
  output logic data_take_q,
  output logic rd_valid_q,
  output logic [7:0] rd_data_q,
  output logic done_q,
  output logic nack_q
);
  import ira_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_BIT, M_NEXT, M_STOP
  } ira_mst_state_type;
  typedef enum logic [2:0] {
    K_ADDR_W, K_PTR, K_WDATA, K_ADDR_R, K_RDATA
  } ira_kind_type;

  ira_mst_state_type st_q;
  ira_kind_type kind_q;
  ira_op_type op_q;
  logic [3:0] qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bidx_q;
  logic [7:0] txb_q;
  logic [7:0] rxb_q;
  logic [7:0] ptr_l_q;
  logic [7:0] len_q;
  logic last_q;
  logic ack_ok_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic tick;

  assign link.m_scl_o = 1'b0;
  assign link.m_sda_o = 1'b0;
  assign link.m_scl_oe = scl_oe_q;
  assign link.m_sda_oe = sda_oe_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else if (ce) begin
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // Clock divider producing the four quarters of each bit cell
  assign tick = (qcnt_q == QUARTER_LAST) &&
    (st_q == M_START || st_q == M_BIT || st_q == M_STOP);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qcnt_q <= 4'h0;
      ph_q <= PH_SET;
    end else if (ce) begin
      if (!(st_q == M_START || st_q == M_BIT || st_q == M_STOP)) begin
        qcnt_q <= 4'h0;
        ph_q <= PH_SET;
      end else if (tick) begin
        qcnt_q <= 4'h0;
        ph_q <= ph_q + 2'h1;
      end else begin
        qcnt_q <= qcnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= M_IDLE;
      kind_q <= K_ADDR_W;
      op_q <= OP_WRITE;
      bidx_q <= BIT_FIRST;
      txb_q <= 8'h00;
      rxb_q <= 8'h00;
      ptr_l_q <= PTR_RESET;
      len_q <= LEN_ZERO;
      last_q <= 1'b0;
      ack_ok_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      busy_q <= 1'b0;
      data_take_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (ce) begin
      data_take_q <= 1'b0;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
      case (st_q)
        M_IDLE: begin
          if (cmd_valid) begin
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            op_q <= cmd_op;
            ptr_l_q <= cmd_ptr;
            len_q <= (cmd_op == OP_READ && cmd_len == LEN_ZERO) ?
              LEN_ONE : cmd_len;
            kind_q <= K_ADDR_W;
            // Recovery after a suspended bus is a lone STOP (see R9)
            st_q <= (cmd_op == OP_RECOVER) ? M_STOP : M_START;
          end
        end
        M_START: begin
          if (tick) begin
            case (ph_q)
              PH_SET: sda_oe_q <= 1'b0;
              PH_RISE: scl_oe_q <= 1'b0;
              PH_HOLD: sda_oe_q <= 1'b1;
              default: begin
                scl_oe_q <= 1'b1;
                bidx_q <= BIT_FIRST;
                st_q <= M_BIT;
                txb_q <= (kind_q == K_ADDR_R) ? {SLAVE_ADDR, RW_READ} :
                  {SLAVE_ADDR, RW_WRITE}; // see R1
              end
            endcase
          end
        end
        M_BIT: begin
          if (tick) begin
            case (ph_q)
              PH_SET: begin
                if (bidx_q == BIT_ACK) begin
                  // Ack our reads, NACK the last one (see R12) (see R8)
                  sda_oe_q <= (kind_q == K_RDATA) ? !last_q : 1'b0;
                end else if (kind_q == K_RDATA) begin
                  sda_oe_q <= 1'b0;
                end else begin
                  sda_oe_q <= ira_od_oe(txb_q[7]);
                  txb_q <= {txb_q[6:0], 1'b0};
                end
              end
              PH_RISE: scl_oe_q <= 1'b0;
              PH_HOLD: begin
                if (bidx_q == BIT_ACK) begin
                  ack_ok_q <= !sda_s2_q;
                end else begin
                  rxb_q <= {rxb_q[6:0], sda_s2_q};
                end
              end
              default: begin
                scl_oe_q <= 1'b1;
                if (bidx_q == BIT_ACK) begin
                  st_q <= M_NEXT;
                end else begin
                  bidx_q <= bidx_q + BIT_STEP;
                end
              end
            endcase
          end
        end
        M_NEXT: begin
          bidx_q <= BIT_FIRST;
          if (kind_q != K_RDATA && !ack_ok_q) begin
            nack_q <= 1'b1;
            st_q <= M_STOP;
          end else begin
            case (kind_q)
              K_ADDR_W: begin
                kind_q <= K_PTR;
                txb_q <= ptr_l_q;
                st_q <= M_BIT;
              end
              K_PTR: begin
                if (op_q == OP_READ) begin
                  // Pointer set, then repeated START to read (see R7)
                  kind_q <= K_ADDR_R;
                  st_q <= M_START;
                end else if (len_q == LEN_ZERO) begin
                  st_q <= M_STOP;
                end else begin
                  kind_q <= K_WDATA;
                  txb_q <= wr_data;
                  data_take_q <= 1'b1;
                  st_q <= M_BIT;
                end
              end
              K_WDATA: begin
                len_q <= len_q - LEN_ONE;
                if (len_q == LEN_ONE) begin
                  st_q <= M_STOP;
                end else begin
                  txb_q <= wr_data;
                  data_take_q <= 1'b1;
                  st_q <= M_BIT;
                end
              end
              K_ADDR_R: begin
                kind_q <= K_RDATA;
                last_q <= (len_q == LEN_ONE);
                st_q <= M_BIT;
              end
              default: begin
                rd_data_q <= rxb_q;
                rd_valid_q <= 1'b1;
                len_q <= len_q - LEN_ONE;
                last_q <= (len_q == LEN_TWO);
                st_q <= (len_q == LEN_ONE) ? M_STOP : M_BIT;
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            case (ph_q)
              PH_SET: sda_oe_q <= 1'b1;
              PH_RISE: scl_oe_q <= 1'b0;
              PH_HOLD: sda_oe_q <= 1'b0;
              default: begin
                st_q <= M_IDLE;
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            endcase
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end
endmodule : ira_master

// file: testbench/ira_link_asserts.sv
`timescale 1ns/1ps
module ira_link_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_OPEN_DRAIN: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
    else $error("Link line driven to a high level");
  AST_RESET_RELEASE: assert property ($rose(rst_n) |->
    !m_scl_oe && !m_sda_oe && !s_sda_oe)
    else $error("Line still pulled low after reset");
  AST_NO_CONTENTION: assert property (scl && s_sda_oe |-> !m_sda_oe)
    else $error("Both ends pull the data line");
  AST_START_BY_MASTER: assert property (
    scl && $past(scl) && $fell(sda) |-> m_sda_oe)
    else $error("Start edge not made by the master end");
  AST_DEV_STABLE: assert property (
    scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("Device data changed while clock high");
  AST_DEV_DRIVE_CLK_LOW: assert property (
    $rose(s_sda_oe) |-> !scl)
    else $error("Device starts pulling data with clock high");
  AST_QUIET_AFTER_STOP: assert property (
    scl && $past(scl) && $rose(sda) |-> !s_sda_oe [*4])
    else $error("Device drives data line after stop");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*2])
    else $error("Clock low phase too short");
  AST_DEV_DRIVE_BOUNDED: assert property (
    $rose(s_sda_oe) |-> ##[1:100] !s_sda_oe)
    else $error("Device holds the data line too long");
endmodule : ira_link_asserts

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import ira_pkg::*;
  logic clk_sys;
  logic rst_n;
  logic ce;
  logic cmd_valid;
  ira_op_type cmd_op;
  logic [7:0] cmd_ptr, cmd_len, wr_data, usr_addr;
  logic m_busy, m_take, m_rd_valid, m_done, m_nack, d_stb, d_busy;
  logic [7:0] m_rdata, d_rdata, d_waddr, d_wdata, d_ptr;
  int fails;
  int checked;
  int seed;
  int ptr;
  int bank [256];
  logic [7:0] wq [$];

  ira_link_if link_if();

  ira_master ira_master_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .link(link_if.master), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wr_data(wr_data),
    .busy_q(m_busy), .data_take_q(m_take), .rd_valid_q(m_rd_valid),
    .rd_data_q(m_rdata), .done_q(m_done), .nack_q(m_nack));
  ira_device ira_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .link(link_if.device), .usr_addr(usr_addr), .usr_rd_data_q(d_rdata),
    .wr_stb_q(d_stb), .wr_addr_q(d_waddr), .wr_data_q(d_wdata),
    .ptr_q(d_ptr), .busy_q(d_busy));
  ira_link_asserts ira_link_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .m_scl_o(link_if.m_scl_o), .m_scl_oe(link_if.m_scl_oe),
    .m_sda_o(link_if.m_sda_o), .m_sda_oe(link_if.m_sda_oe),
    .s_sda_o(link_if.s_sda_o), .s_sda_oe(link_if.s_sda_oe),
    .scl(link_if.scl), .sda(link_if.sda));

  initial begin
    clk_sys = 1'b0;
    forever begin
      #10 clk_sys = ~clk_sys;
    end
  end

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_bank(input logic [7:0] a);
    usr_addr = a;
    tick();
    tick();
    check(d_rdata, bank[a][7:0]);
  endtask : chk_bank

  // One master command, checked byte by byte against the model
  task automatic run_cmd(input ira_op_type op, input logic [7:0] p,
      input logic [7:0] n);
    int k;
    int wi;
    int rn;
    int cnt;
    k = 0;
    wi = 0;
    rn = 0;
    cnt = 0;
    wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
    cmd_op = op;
    cmd_ptr = p;
    cmd_len = n;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    check(m_busy, 1'b1);
    if (op != OP_RECOVER) begin
      ptr = p;
    end
    while (m_done !== 1'b1 && cnt < 3000) begin
      if (m_take === 1'b1) begin
        k++;
        wr_data = (k < wq.size()) ? wq[k] : 8'h00;
      end
      if (d_stb === 1'b1) begin
        check(d_waddr, 8'(ptr));
        check(d_wdata, wq[wi]);
        check(d_busy, 1'b1);
        bank[ptr] = wq[wi];
        ptr = (ptr + 1) % 256;
        wi++;
      end
      if (m_rd_valid === 1'b1) begin
        check(m_rdata, bank[ptr][7:0]);
        ptr = (ptr + 1) % 256;
        rn++;
      end
      cnt++;
      tick();
    end
    if (cnt >= 3000) begin
      fails++;
      $display("[FAIL] %0t ns: command never completed", $time);
    end
    check(m_nack, 1'b0);
    if (op == OP_WRITE) begin
      check(8'(wi), n);
    end
    if (op == OP_READ) begin
      check(8'(rn), (n == 8'h00) ? 8'h01 : n);
    end
    repeat (4) tick();
    check(d_busy, 1'b0);
    check(m_busy, 1'b0);
    check(d_ptr, 8'(ptr));
    check(link_if.sda, 1'b1);
    check(link_if.scl, 1'b1);
  endtask : run_cmd

  initial begin
    #1_000_000;
    fails++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    seed = 32'ha391;
    fails = 0;
    checked = 0;
    ptr = 0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_WRITE;
    cmd_ptr = 8'h00;
    cmd_len = 8'h00;
    wr_data = 8'h00;
    usr_addr = 8'h00;
    foreach (bank[i]) begin
      bank[i] = 0;
    end
    rst_n = 1'b0;
    repeat (20) tick();
    rst_n = 1'b1;
    tick();
    check(d_ptr, 8'h00);
    check(link_if.sda, 1'b1);
    chk_bank(8'h5a);
    // Pointer-only write, then a burst that wraps the bank
    run_cmd(OP_WRITE, 8'h10, 8'h00);
    chk_bank(8'h10);
    for (int i = 0; i < 4; i++) begin
      wq.push_back(8'($random(seed)));
    end
    run_cmd(OP_WRITE, 8'hfe, 8'h04);
    for (int i = 0; i < 4; i++) begin
      chk_bank(8'(8'hfe + i));
    end
    wq = {};
    run_cmd(OP_READ, 8'hfd, 8'h06);
    run_cmd(OP_READ, 8'h00, 8'h00);
    run_cmd(OP_RECOVER, 8'h00, 8'h00);
    for (int j = 0; j < 8; j++) begin
      wq = {};
      cmd_len = 8'(($random(seed) & 3) + 1);
      for (int i = 0; i < cmd_len; i++) begin
        wq.push_back(8'($random(seed)));
      end
      run_cmd(($random(seed) & 1) ? OP_READ : OP_WRITE,
        8'($random(seed)), cmd_len);
    end
    // Clock enable low freezes both ends
    ce = 1'b0;
    cmd_op = OP_RECOVER;
    cmd_valid = 1'b1;
    repeat (4) tick();
    check(m_busy, 1'b0);
    check(link_if.sda, 1'b1);
    ce = 1'b1;
    cmd_valid = 1'b0;
    tick();
    check(m_busy, 1'b0);
    check(d_ptr, 8'(ptr));
    // Reset in the middle of a frame
    wq = {8'h77, 8'h88};
    wr_data = 8'h77;
    cmd_op = OP_WRITE;
    cmd_ptr = 8'h20;
    cmd_len = 8'h02;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    repeat (100) tick();
    rst_n = 1'b0;
    tick();
    tick();
    rst_n = 1'b1;
    tick();
    foreach (bank[i]) begin
      bank[i] = 0;
    end
    ptr = 0;
    check(d_ptr, 8'h00);
    check(link_if.sda, 1'b1);
    chk_bank(8'hfe);
    wq = {};
    run_cmd(OP_READ, 8'hfe, 8'h02);
    print_verdict();
  end
endmodule : tb
